// file: blc_map.vh
`ifndef BLC_MAP_VH
`define BLC_MAP_VH
// operating state codes
`define BLC_ST_STANDBY   2'h0
`define BLC_ST_BACKLIGHT 2'h1
// sample rate select codes
`define BLC_SR_800K      2'h0
`define BLC_SR_4M        2'h1
`define BLC_SR_24M       2'h3
// clock and times
`define BLC_CLK_MHZ      50
`define BLC_RESET_US     250
`define BLC_RESET_CYC    (`BLC_RESET_US * `BLC_CLK_MHZ)
// loss-of-pwm timeouts in clocks: 0.68 ms, 4.1 ms, 20.5 ms
`define BLC_TO_24M_CYC   23'h0084D0
`define BLC_TO_4M_CYC    23'h0320C8
`define BLC_TO_800K_CYC  23'h0FA3E8
// sample dividers of the 50 MHz clock
`define BLC_DIV_24M      6'h02
`define BLC_DIV_4M       6'h0C
`define BLC_DIV_800K     6'h3E
// glitch filter lengths in 20 ns clocks: 100, 140, 200 ns
`define BLC_GF1_CYC      4'h5
`define BLC_GF2_CYC      4'h7
`define BLC_GF3_CYC      4'hA
// ramp-down base 512 us
`define BLC_RAMP_BASE_US 512
`define BLC_RAMP_BASE_CYC (`BLC_RAMP_BASE_US * `BLC_CLK_MHZ)
// analog select encodings (ma / 100 mv)
`define BLC_OCP0_MA      12'h384
`define BLC_OCP1_MA      12'h708
`define BLC_OCP2_MA      12'hA8C
`define BLC_OCP3_MA      12'hD48
`define BLC_OVP0_DV      9'h0AF
`define BLC_OVP1_DV      9'h0F0
`define BLC_OVP2_DV      9'h136
`define BLC_OVP3_DV      9'h17C
`define BLC_OVP4_DV      9'h19F
`define BLC_FSW0_KHZ     11'h1F4
`define BLC_FSW1_KHZ     11'h3E8
`define BLC_DUTY_BITS    11
`endif

// file: blc_sync.v
`timescale 1ns/1ps
module blc_sync
#(
    parameter W = 2
)
(
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
reg [W-1:0] meta_r;
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        meta_r <= {W{1'b0}};
        q      <= {W{1'b0}};
    end
    else
    begin
        meta_r <= d;
        q      <= meta_r;
    end
end
endmodule // blc_sync

// file: blc_ctrl.v
`timescale 1ns/1ps
`include "blc_map.vh"
// Overview of operation
// - enable low: shutdown, settings to defaults
// - shutdown keeps serial port disabled
// - enable high: standby, port gated by power-good
// - power-good after supply ok and reset interval
// - enable low cuts current at once
// - serial exit ramps current down
// - pwm timeout scales with sample rate
// - two-bit pulse filter rejects glitches
// - current-limit select maps to four limits
// - overvoltage select, top bit gives max
// - frequency select gives 500 or 1000 kHz
// - eleven-bit duty measurement
// - state field picks standby, backlight, flash
// - pwm loss turns boost off in backlight state
// - four-bit ramp-down duration setting
module blc_ctrl
#(
    parameter RESET_CYC = `BLC_RESET_CYC,
    parameter RAMP_BASE = `BLC_RAMP_BASE_CYC
)
(
    input  wire        clk,
    input  wire        rst,
    input  wire        hardware_enable_pin,
    input  wire        pwm_pin,
    input  wire        supply_ok,
    input  wire [1:0]  state_sel,
    input  wire        pwm_dim_en,
    input  wire [1:0]  sample_rate_sel,
    input  wire [1:0]  pulse_filter_sel,
    input  wire [3:0]  ramp_down_sel,
    input  wire [1:0]  switch_current_limit_select,
    input  wire [2:0]  overvoltage_threshold_select,
    input  wire        boost_freq_sel,
    output reg         power_good_flag,
    output reg         serial_port_en,
    output reg         settings_reset,
    output reg  [1:0]  op_state,
    output reg         led_on,
    output reg         ramping_down,
    output reg         boost_on,
    output reg         pwm_timeout,
    output reg  [10:0] duty_measure_resolution,
    output reg  [11:0] ocp_limit_ma,
    output reg  [8:0]  ovp_level_dv,
    output reg  [10:0] fsw_khz
);
////////////////////////////////////////////////////////////////////////////////
wire [2:0] sync_w;
wire       en_s = sync_w[2];
wire       pwm_s = sync_w[1];
// the supply comparator is asynchronous to clk as well
wire       supply_s = sync_w[0];
blc_sync #(.W(3)) u_sync
(
    .clk (clk),
    .rst (rst),
    .d   ({hardware_enable_pin, pwm_pin, supply_ok}),
    .q   (sync_w)
);
////////////////////////////////////////////////////////////////////////////////
function [22:0] to_cyc;
    input [1:0] sr;
    begin
        case (sr)
            `BLC_SR_24M: to_cyc = `BLC_TO_24M_CYC;
            `BLC_SR_4M:  to_cyc = `BLC_TO_4M_CYC;
            default:     to_cyc = `BLC_TO_800K_CYC;
        endcase
    end
endfunction
function [5:0] div_cyc;
    input [1:0] sr;
    begin
        case (sr)
            `BLC_SR_24M: div_cyc = `BLC_DIV_24M;
            `BLC_SR_4M:  div_cyc = `BLC_DIV_4M;
            default:     div_cyc = `BLC_DIV_800K;
        endcase
    end
endfunction
////////////////////////////////////////////////////////////////////////////////
// power-good: supply sensed, then the reset interval must pass
reg [14:0] por_cnt_r;
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        por_cnt_r       <= 15'h0000;
        power_good_flag <= 1'b0;
    end
    else if (!supply_s)
    begin
        por_cnt_r       <= 15'h0000;
        power_good_flag <= 1'b0;
    end
    else if (por_cnt_r < RESET_CYC[14:0] - 15'h0001)
        por_cnt_r <= por_cnt_r + 15'h0001;
    else
        power_good_flag <= 1'b1;
end
////////////////////////////////////////////////////////////////////////////////
// glitch filter: level must hold for gf_len + 1 clocks before it is accepted
reg [3:0] gf_cnt_r;
reg       pwm_f_r;
reg [3:0] gf_len;
always @*
begin
    case (pulse_filter_sel)
        2'h1:    gf_len = `BLC_GF1_CYC;
        2'h2:    gf_len = `BLC_GF2_CYC;
        2'h3:    gf_len = `BLC_GF3_CYC;
        default: gf_len = 4'h0;
    endcase
end
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        gf_cnt_r <= 4'h0;
        pwm_f_r  <= 1'b0;
    end
    else if (pwm_s == pwm_f_r)
        gf_cnt_r <= 4'h0;
    else if (gf_cnt_r >= gf_len)
    begin
        pwm_f_r  <= pwm_s;
        gf_cnt_r <= 4'h0;
    end
    else
        gf_cnt_r <= gf_cnt_r + 4'h1;
end
////////////////////////////////////////////////////////////////////////////////
// sampled duty measurement: high and total sample counts per period
reg [5:0]  div_r;
reg        smp_last_r;
reg [15:0] hi_cnt_r;
reg [15:0] per_cnt_r;
reg [22:0] to_cnt_r;
wire       smp_tick = (div_r == 6'h00);
wire       rise = smp_tick && pwm_f_r && !smp_last_r;
reg [26:0] duty_w;
always @*
begin
    duty_w = 27'h0;
    if (per_cnt_r != 16'h0000)
        duty_w = ({hi_cnt_r, 11'h000} - {11'h000, hi_cnt_r}) / {11'h000, per_cnt_r};
end
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        div_r                   <= 6'h00;
        smp_last_r              <= 1'b0;
        hi_cnt_r                <= 16'h0000;
        per_cnt_r               <= 16'h0000;
        to_cnt_r                <= 23'h000000;
        pwm_timeout             <= 1'b0;
        duty_measure_resolution <= 11'h7FF;
    end
    else if (!en_s)
    begin
        div_r       <= 6'h00;
        smp_last_r  <= 1'b0;
        hi_cnt_r    <= 16'h0000;
        per_cnt_r   <= 16'h0000;
        to_cnt_r    <= 23'h000000;
        pwm_timeout <= 1'b0;
        duty_measure_resolution <= 11'h7FF;
    end
    else
    begin
        div_r <= smp_tick ? div_cyc(sample_rate_sel) - 6'h01 : div_r - 6'h01;
        if (smp_tick)
        begin
            smp_last_r <= pwm_f_r;
            if (rise)
            begin
                if (per_cnt_r != 16'h0000)
                    duty_measure_resolution <= duty_w[10:0];
                hi_cnt_r  <= 16'h0001;
                per_cnt_r <= 16'h0001;
            end
            else
            begin
                if (pwm_f_r && hi_cnt_r != 16'hFFFF)
                    hi_cnt_r <= hi_cnt_r + 16'h0001;
                if (per_cnt_r != 16'hFFFF)
                    per_cnt_r <= per_cnt_r + 16'h0001;
            end
        end
        // any accepted edge restarts the loss timer
        if (!pwm_dim_en || pwm_f_r != smp_last_r)
        begin
            to_cnt_r    <= 23'h000000;
            pwm_timeout <= 1'b0;
        end
        else if (to_cnt_r >= to_cyc(sample_rate_sel) - 23'h000001)
            pwm_timeout <= 1'b1;
        else
            to_cnt_r <= to_cnt_r + 23'h000001;
    end
end
////////////////////////////////////////////////////////////////////////////////
// state control; ramp length is base << ramp_down_sel
reg [30:0] ramp_cnt_r;
wire [30:0] ramp_len = RAMP_BASE[30:0] << ramp_down_sel;
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        op_state       <= `BLC_ST_STANDBY;
        led_on         <= 1'b0;
        ramping_down   <= 1'b0;
        ramp_cnt_r     <= 31'h00000000;
        serial_port_en <= 1'b0;
        settings_reset <= 1'b1;
        boost_on       <= 1'b0;
    end
    else if (!en_s)
    begin
        settings_reset <= 1'b1;
        serial_port_en <= 1'b0;
        op_state       <= `BLC_ST_STANDBY;
        led_on         <= 1'b0;
        ramping_down   <= 1'b0;
        ramp_cnt_r     <= 31'h00000000;
        boost_on       <= 1'b0;
    end
    else
    begin
        settings_reset <= 1'b0;
        serial_port_en <= power_good_flag;
        op_state       <= state_sel[1] ? state_sel : (state_sel & 2'h1);
        if (state_sel != `BLC_ST_STANDBY)
        begin
            led_on       <= 1'b1;
            ramping_down <= 1'b0;
            ramp_cnt_r   <= 31'h00000000;
        end
        else if (led_on)
        begin
            if (ramp_cnt_r >= ramp_len - 31'h00000001)
            begin
                led_on       <= 1'b0;
                ramping_down <= 1'b0;
            end
            else
            begin
                ramping_down <= 1'b1;
                ramp_cnt_r   <= ramp_cnt_r + 31'h00000001;
            end
        end
        // flash current ignores pwm, so timeout only hits backlight
        boost_on <= led_on && !(pwm_timeout && op_state == `BLC_ST_BACKLIGHT);
    end
end
////////////////////////////////////////////////////////////////////////////////
// analog trim decodes, registered
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        ocp_limit_ma <= 12'h000;
        ovp_level_dv <= 9'h000;
        fsw_khz      <= 11'h000;
    end
    else
    begin
        case (switch_current_limit_select)
            2'h0:    ocp_limit_ma <= `BLC_OCP0_MA;
            2'h1:    ocp_limit_ma <= `BLC_OCP1_MA;
            2'h2:    ocp_limit_ma <= `BLC_OCP2_MA;
            default: ocp_limit_ma <= `BLC_OCP3_MA;
        endcase
        case (overvoltage_threshold_select)
            3'h0:    ovp_level_dv <= `BLC_OVP0_DV;
            3'h1:    ovp_level_dv <= `BLC_OVP1_DV;
            3'h2:    ovp_level_dv <= `BLC_OVP2_DV;
            3'h3:    ovp_level_dv <= `BLC_OVP3_DV;
            default: ovp_level_dv <= `BLC_OVP4_DV;
        endcase
        fsw_khz <= boost_freq_sel ? `BLC_FSW1_KHZ : `BLC_FSW0_KHZ;
    end
end
endmodule // blc_ctrl

// file: blc_host.sv
`timescale 1ns/1ps
module blc_host
(
    input  wire       clk,
    input  wire       run,
    input  wire [9:0] hi_cyc,
    input  wire [9:0] lo_cyc,
    output reg        pwm_pin
);
    reg [9:0] cnt_r = 10'h000;
    initial pwm_pin = 1'h0;
    // a stopped source leaves the pin at its pull-down level
    always @(posedge clk)
        if (!run)
            {pwm_pin, cnt_r} <= #1 11'h000;
        else if (cnt_r == 10'h000)
            {pwm_pin, cnt_r} <= #1 {~pwm_pin, (pwm_pin ? lo_cyc : hi_cyc) - 10'h001};
        else
            cnt_r <= #1 cnt_r - 10'h001;
endmodule // blc_host

// file: blc_ctrl_chk.sv
`timescale 1ns/1ps
module blc_ctrl_chk
(
    input wire        clk,
    input wire        rst,
    input wire        hardware_enable_pin,
    input wire        pwm_pin,
    input wire [1:0]  sample_rate_sel,
    input wire [1:0]  switch_current_limit_select,
    input wire [2:0]  overvoltage_threshold_select,
    input wire        boost_freq_sel,
    input wire        serial_port_en,
    input wire        settings_reset,
    input wire        led_on,
    input wire        ramping_down,
    input wire        pwm_timeout,
    input wire [11:0] ocp_limit_ma,
    input wire [8:0]  ovp_level_dv,
    input wire [10:0] fsw_khz
);
    wire [47:0] ocp_t = 48'hD48A8C708384;
    wire [44:0] ovp_t = 45'h19FBE4D9E0AF;
    wire [2:0]  ovp_i = overvoltage_threshold_select[2] ? 3'h4 : overvoltage_threshold_select;
    // counted from the pin, so the span only looks longer than the synced one
    wire [19:0] to_min = (sample_rate_sel == 2'h3) ? 20'h07724 :
                         (sample_rate_sel == 2'h1) ? 20'h2D0B4 : 20'hE09C0;
    reg  [19:0] quiet_r;
    reg         pwm_d_r;
    always @(posedge clk)
    begin
        pwm_d_r <= pwm_pin;
        quiet_r <= (rst || pwm_pin != pwm_d_r) ? 20'h00000 : quiet_r + {19'h0, ~&quiet_r};
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_off_reset: assert property (!hardware_enable_pin [*3] |=> settings_reset)
        else $error("settings kept after enable low");
    chk_off_port: assert property (!hardware_enable_pin [*4] |=> !serial_port_en)
        else $error("serial port on in shutdown");
    chk_off_cut: assert property (!hardware_enable_pin [*3] |=> !led_on)
        else $error("led on after enable low");
    chk_ramp_hold: assert property ($rose(ramping_down) |-> led_on)
        else $error("led off at ramp start");
    chk_loss_time: assert property ($rose(pwm_timeout) |-> quiet_r >= to_min)
        else $error("pwm timeout too early");
    chk_ocp_map: assert property (!$past(rst) |->
        ocp_limit_ma == ocp_t[12 * $past(switch_current_limit_select) +: 12])
        else $error("current limit wrong");
    chk_ovp_map: assert property (!$past(rst) |->
        ovp_level_dv == ovp_t[9 * $past(ovp_i) +: 9])
        else $error("overvoltage level wrong");
    chk_fsw_map: assert property (!$past(rst) |->
        fsw_khz == ($past(boost_freq_sel) ? 11'h3E8 : 11'h1F4))
        else $error("switching frequency wrong");
endmodule // blc_ctrl_chk
bind blc_ctrl blc_ctrl_chk blc_ctrl_chk_i (.clk, .rst, .hardware_enable_pin, .pwm_pin,
    .sample_rate_sel, .switch_current_limit_select, .overvoltage_threshold_select,
    .boost_freq_sel, .serial_port_en, .settings_reset, .led_on, .ramping_down,
    .pwm_timeout, .ocp_limit_ma, .ovp_level_dv, .fsw_khz);

// file: blc_ctrl_tb.sv
`timescale 1ns/1ps
module blc_ctrl_tb;
    reg         clk, rst, hardware_enable_pin, supply_ok, pwm_dim_en, boost_freq_sel, run;
    reg  [1:0]  state_sel, sample_rate_sel, pulse_filter_sel, switch_current_limit_select;
    reg  [2:0]  overvoltage_threshold_select;
    reg  [3:0]  ramp_down_sel;
    reg  [9:0]  hi_cyc, lo_cyc;
    wire        pwm_pin, power_good_flag, serial_port_en, settings_reset, led_on;
    wire        ramping_down, boost_on, pwm_timeout;
    wire [1:0]  op_state;
    wire [10:0] duty_measure_resolution;
    integer     n_errors = 0, check_count = 0, seed = 11962, i, n, e;
    always #10 clk = ~clk;
    blc_ctrl #(.RESET_CYC(10), .RAMP_BASE(4)) blc_ctrl_i (.clk, .rst, .hardware_enable_pin,
        .pwm_pin, .supply_ok, .state_sel, .pwm_dim_en, .sample_rate_sel, .pulse_filter_sel,
        .ramp_down_sel, .switch_current_limit_select, .overvoltage_threshold_select,
        .boost_freq_sel, .power_good_flag, .serial_port_en, .settings_reset, .op_state,
        .led_on, .ramping_down, .boost_on, .pwm_timeout, .duty_measure_resolution,
        .ocp_limit_ma(), .ovp_level_dv(), .fsw_khz());
    blc_host blc_host_i (.clk, .run, .hi_cyc, .lo_cyc, .pwm_pin);
    ////////////////////////////////////////////////////////////
    function integer exp_duty(input integer h);
        exp_duty = h * 2047 / 1000;
    endfunction
    task wt(input integer c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task ck(input bit ok);
        check_count = check_count + 1;
        if (!ok)
        begin
            n_errors = n_errors + 1;
            $display("Error %0t check %0d failed", $time, check_count);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #1800000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        {clk, rst, hardware_enable_pin, supply_ok, pwm_dim_en, boost_freq_sel, run} = 7'h20;
        {state_sel, sample_rate_sel, pulse_filter_sel, switch_current_limit_select} = 8'h30;
        {overvoltage_threshold_select, ramp_down_sel, hi_cyc, lo_cyc} = 27'h0;
        wt(10);
        rst = 1'h0;
        wt(2);
        ck(settings_reset === 1'h1 && serial_port_en === 1'h0);
        hardware_enable_pin = 1'h1;
        wt(20);
        ck(power_good_flag === 1'h0 && serial_port_en === 1'h0);
        supply_ok = 1'h1;
        for (n = 0; n < 40 && power_good_flag !== 1'h1; n = n + 1) wt(1);
        ck(n >= 9 && n <= 13);
        wt(2);
        ck(serial_port_en === 1'h1 && settings_reset === 1'h0);
        $display("test power done");
        // the first eight steps reach every select code, the rest are random
        for (i = 0; i < 24; i = i + 1)
        begin
            e = (i < 8) ? i * 9 : $random(seed);
            {boost_freq_sel, overvoltage_threshold_select,
                switch_current_limit_select} = e[5:0];
            wt(2);
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            state_sel = i[1:0];
            wt(40);
            ck(led_on === (i > 0) && (i > 1 ? op_state[1] === 1'h1 : op_state === i[1:0]));
        end
        for (i = 1; i < 4; i = i + 2)
        begin
            ramp_down_sel = i[3:0];
            state_sel = 2'h1;
            wt(40);
            state_sel = 2'h0;
            wt(3);
            ck(ramping_down === 1'h1 && led_on === 1'h1);
            for (n = 3; n < 99 && led_on !== 1'h0; n = n + 1) wt(1);
            ck(n >= (4 << i) && n <= (4 << i) + 5);
        end
        state_sel = 2'h1;
        wt(40);
        hardware_enable_pin = 1'h0;
        wt(4);
        ck(led_on === 1'h0 && ramping_down === 1'h0 && settings_reset === 1'h1);
        hardware_enable_pin = 1'h1;
        wt(40);
        $display("test state done");
        pwm_dim_en = 1'h1;
        run = 1'h1;
        for (i = 0; i < 5; i = i + 1)
        begin
            e = (i == 0) ? 100 : 100 + {$random(seed)} % 800;
            {hi_cyc, lo_cyc} = {e[9:0], 10'h3E8 - e[9:0]};
            wt(3000);
            e = exp_duty(e);
            ck(duty_measure_resolution + 16 >= e && duty_measure_resolution <= e + 16);
        end
        run = 1'h0;
        for (n = 0; n < 40000 && pwm_timeout !== 1'h1; n = n + 1) wt(1);
        ck(n >= 30500 && n <= 37510);
        wt(2);
        ck(boost_on === 1'h0);
        {hi_cyc, lo_cyc} = {10'h002, 10'h3E6};
        run = 1'h1;
        // glitches shorter than any filter setting must not count as pulses
        for (i = 1; i < 4; i = i + 1)
        begin
            pulse_filter_sel = i[1:0];
            wt(3000);
            ck(pwm_timeout === 1'h1);
        end
        pulse_filter_sel = 2'h0;
        {hi_cyc, lo_cyc} = {10'h0C8, 10'h320};
        wt(2100);
        ck(pwm_timeout === 1'h0 && boost_on === 1'h1);
        $display("test pwm done");
        tally_and_finish;
    end
endmodule // blc_ctrl_tb
